// >>> design/ptf_pkg.sv
package ptf_pkg;
	// ************************************************************
	// widths and depths
	// ************************************************************
	localparam int DATA_W      = 64;
	localparam int ADDR_W      = 32;
	localparam int WFIFO_DEPTH = 16;
	localparam int AFIFO_DEPTH = 4;
	localparam int CMD_W       = 4;
	localparam int REGION_W    = 3;
	localparam int STATE_W     = 3;
	localparam int AEMPTY_LEVEL = 4;
	localparam int NUM_REGIONS  = 6;
	// app enable hold and post-release wait, in clocks
	localparam int OE_HOLD      = 5;
	localparam int OE_GAP       = 3;

	// ************************************************************
	// target state counter codes
	// ************************************************************
	typedef enum logic [2:0] {
		PTF_ST_IDLE  = 3'h0,
		PTF_ST_ADDR  = 3'h1,
		PTF_ST_WDATA = 3'h2,
		PTF_ST_RDATA = 3'h3,
		PTF_ST_DONE  = 3'h4
	} ptf_state_type;
endpackage

// >>> design/ptf_if.sv
`timescale 1ns/1ns
interface ptf_if;
	logic                                 tgt_fifo_clear_n;
	logic                                 tgt_req_n;
	logic                                 tgt_ready;
	logic                                 tgt_addr_oe_n;
	logic [ptf_pkg::ADDR_W-1:0]           tgt_addr;
	logic [ptf_pkg::CMD_W-1:0]            tgt_cmd;
	logic [ptf_pkg::REGION_W-1:0]         tgt_region;
	logic [ptf_pkg::STATE_W-1:0]          tgt_state_cnt;
	logic                                 tgt_wr_data_en_n;
	logic [ptf_pkg::DATA_W-1:0]           data_to_fabric;
	logic                                 tgt_wr_fifo_empty_n;
	logic                                 tgt_wr_fifo_almost_empty_n;
	logic                                 tgt_wr_fifo_full_n;

	modport core (
		input  tgt_fifo_clear_n, tgt_addr_oe_n, tgt_wr_data_en_n,
		output tgt_req_n, tgt_ready, tgt_addr, tgt_cmd, tgt_region, tgt_state_cnt,
		output data_to_fabric, tgt_wr_fifo_empty_n, tgt_wr_fifo_almost_empty_n,
		output tgt_wr_fifo_full_n
	);
	modport app (
		output tgt_fifo_clear_n, tgt_addr_oe_n, tgt_wr_data_en_n,
		input  tgt_req_n, tgt_ready, tgt_addr, tgt_cmd, tgt_region, tgt_state_cnt,
		input  data_to_fabric, tgt_wr_fifo_empty_n, tgt_wr_fifo_almost_empty_n,
		input  tgt_wr_fifo_full_n
	);
endinterface

// >>> design/ptf_core.sv
`timescale 1ns/1ns
// Functional notes
// RULE1: application clears all target fifos, active low
// RULE2: request low while target transfer waits
// RULE3: request held while address fifo nonempty
// RULE4: ready low during bus reset or clear
// RULE5: application enables address and command read; only the address waits for the enable here, the command follows the head entry
// RULE6: only needed address cycles, bits kept
// RULE7: four-bit command valid with request low
// RULE8: command and region sampled under request
// RULE9: three-bit matched region, wide ones even
// RULE10: three-bit target state counter output
// RULE11: write-data enable pops one word per edge
// RULE12: valid word each enabled nonempty read
// RULE13: empty flag when write fifo empty
// RULE14: almost-empty flag at four entries left
// RULE15: full flag low when write fifo full
// RULE16: read registers under request, synchronise flags
module ptf_core #(
	parameter int DATA_W      = ptf_pkg::DATA_W,
	parameter int ADDR_W      = ptf_pkg::ADDR_W,
	parameter int WFIFO_DEPTH = ptf_pkg::WFIFO_DEPTH,
	parameter int AFIFO_DEPTH = ptf_pkg::AFIFO_DEPTH
) (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire logic                         pci_rst_i,
	input  wire logic                         req_valid_i,
	output      logic                         req_ready_o,
	input  wire logic [ADDR_W-1:0]            req_addr_i,
	input  wire logic [ptf_pkg::CMD_W-1:0]    req_cmd_i,
	input  wire logic [ptf_pkg::REGION_W-1:0] req_region_i,
	input  wire logic                         req_write_i,
	input  wire logic                         wdata_valid_i,
	output      logic                         wdata_ready_o,
	input  wire logic [DATA_W-1:0]            wdata_i,
	ptf_if.core                               port_o
);
	localparam int WAW = $clog2(WFIFO_DEPTH);
	localparam int AAW = $clog2(AFIFO_DEPTH);

	// ************************************************************
	// parameter checks
	// ************************************************************
	initial begin
		if (WFIFO_DEPTH < 8 || (1 << WAW) != WFIFO_DEPTH)
			$error("write fifo depth must be a power of two, at least 8");
		if (AFIFO_DEPTH < 2 || (1 << AAW) != AFIFO_DEPTH)
			$error("address fifo depth must be a power of two, at least 2");
		// the carrier interface fixes these widths
		if (DATA_W != ptf_pkg::DATA_W || ADDR_W != ptf_pkg::ADDR_W)
			$error("data and address widths must match the port interface");
		if (ptf_pkg::AEMPTY_LEVEL >= WFIFO_DEPTH)
			$error("almost-empty level must lie below the write fifo depth");
	end

	// ************************************************************
	// application controls
	// ************************************************************
	// the app runs on this clock with registered outputs, so no sync
	// stages: extra latency here would skew the app's pop tracking
	wire clear_n = port_o.tgt_fifo_clear_n;
	wire oe_n    = port_o.tgt_addr_oe_n;
	wire en_n    = port_o.tgt_wr_data_en_n;
	wire clear   = rst_i | ~clear_n; // [RULE1]

	// ************************************************************
	// address/command fifo
	// ************************************************************
	logic [ADDR_W-1:0]            a_addr_q [AFIFO_DEPTH];
	logic [ptf_pkg::CMD_W-1:0]    a_cmd_q  [AFIFO_DEPTH];
	logic [ptf_pkg::REGION_W-1:0] a_reg_q  [AFIFO_DEPTH];
	logic                         a_wr_q   [AFIFO_DEPTH];
	logic [AAW:0]                 a_wp_q, a_rp_q;
	wire [AAW:0] a_cnt   = a_wp_q - a_rp_q;
	wire         a_empty = (a_cnt == '0);
	wire         a_full  = (a_cnt == (AAW+1)'(AFIFO_DEPTH));
	// out-of-range region is dropped, never queued
	wire region_ok = (req_region_i < (ptf_pkg::REGION_W)'(ptf_pkg::NUM_REGIONS)); // [RULE9]
	assign req_ready_o = ~a_full & ~clear & ~pci_rst_i;
	wire a_push = req_valid_i & req_ready_o & region_ok;
	logic oe_prev_q;
	// pop on release of the output enable, after the application read the entry
	wire oe_rise = ~oe_prev_q & oe_n;
	wire a_pop   = ~a_empty & oe_rise;

	always_ff @(posedge clk_i) begin
		if (clear) begin
			a_wp_q    <= '0;
			a_rp_q    <= '0;
			oe_prev_q <= 1'b1;
		end else begin
			oe_prev_q <= oe_n;
			if (a_push)
				a_wp_q <= a_wp_q + 1'b1;
			if (a_pop)
				a_rp_q <= a_rp_q + 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (a_push) begin
			a_addr_q[a_wp_q[AAW-1:0]] <= req_addr_i; // [RULE6]
			a_cmd_q[a_wp_q[AAW-1:0]]  <= req_cmd_i;
			a_reg_q[a_wp_q[AAW-1:0]]  <= req_region_i;
			a_wr_q[a_wp_q[AAW-1:0]]   <= req_write_i;
		end
	end

	// ************************************************************
	// request, ready, registers out
	// ************************************************************
	logic                         req_n_q, ready_q;
	logic [ADDR_W-1:0]            addr_q;
	logic [ptf_pkg::CMD_W-1:0]    cmd_q;
	logic [ptf_pkg::REGION_W-1:0] reg_q;
	wire [AAW-1:0] head = a_rp_q[AAW-1:0];
	always_ff @(posedge clk_i) begin
		if (clear) begin
			req_n_q <= 1'b1;
			ready_q <= 1'b0; // [RULE4]
			addr_q  <= '0;
			cmd_q   <= '0;
			reg_q   <= '0;
		end else begin
			// wait for the head's command and region to stand with the request
			req_n_q <= a_empty; // [RULE2] [RULE3]
			ready_q <= ~pci_rst_i; // [RULE4]
			cmd_q   <= a_empty ? cmd_q : a_cmd_q[head]; // [RULE7]
			reg_q   <= a_empty ? reg_q : a_reg_q[head]; // [RULE9]
			// reloads while the enable is low; the app samples at release
			if (~oe_n & ~a_empty)
				addr_q <= a_addr_q[head]; // [RULE5] [RULE6]
		end
	end

	// ************************************************************
	// target state counter
	// ************************************************************
	ptf_pkg::ptf_state_type st_q, st_d;
	wire head_wr = a_wr_q[head];
	// counter follows the head entry only
	always_comb begin
		st_d = st_q;
		case (st_q)
			ptf_pkg::PTF_ST_IDLE:  if (!a_empty) st_d = ptf_pkg::PTF_ST_ADDR;
			ptf_pkg::PTF_ST_ADDR:  if (!oe_n)
				st_d = head_wr ? ptf_pkg::PTF_ST_WDATA : ptf_pkg::PTF_ST_RDATA;
			ptf_pkg::PTF_ST_WDATA: if (a_pop) st_d = ptf_pkg::PTF_ST_DONE;
			ptf_pkg::PTF_ST_RDATA: if (a_pop) st_d = ptf_pkg::PTF_ST_DONE;
			ptf_pkg::PTF_ST_DONE:  st_d = ptf_pkg::PTF_ST_IDLE;
			default:               st_d = ptf_pkg::PTF_ST_IDLE;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (clear)
			st_q <= ptf_pkg::PTF_ST_IDLE;
		else
			st_q <= st_d; // [RULE10]
	end

	// ************************************************************
	// target write data fifo
	// ************************************************************
	logic [DATA_W-1:0] w_mem_q [WFIFO_DEPTH];
	logic [WAW:0]      w_wp_q, w_rp_q;
	logic [DATA_W-1:0] dout_q;
	wire [WAW:0] w_cnt   = w_wp_q - w_rp_q;
	wire         w_empty = (w_cnt == '0);
	wire         w_full  = (w_cnt == (WAW+1)'(WFIFO_DEPTH));
	assign wdata_ready_o = ~w_full & ~clear & ~pci_rst_i;
	wire w_push = wdata_valid_i & wdata_ready_o;
	// no pop while empty, so a held enable cannot underflow
	wire w_pop  = ~en_n & ~w_empty; // [RULE11] [RULE12]
	always_ff @(posedge clk_i) begin
		if (clear) begin
			w_wp_q <= '0;
			w_rp_q <= '0;
			dout_q <= '0;
		end else begin
			if (w_push)
				w_wp_q <= w_wp_q + 1'b1;
			if (w_pop) begin
				w_rp_q <= w_rp_q + 1'b1;
				dout_q <= w_mem_q[w_rp_q[WAW-1:0]]; // [RULE12]
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (w_push)
			w_mem_q[w_wp_q[WAW-1:0]] <= wdata_i;
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign port_o.tgt_req_n                  = req_n_q;
	assign port_o.tgt_ready                  = ready_q;
	assign port_o.tgt_addr                   = addr_q;
	assign port_o.tgt_cmd                    = cmd_q;
	assign port_o.tgt_region                 = reg_q;
	assign port_o.tgt_state_cnt              = st_q;
	assign port_o.data_to_fabric             = dout_q;
	assign port_o.tgt_wr_fifo_empty_n        = ~w_empty; // [RULE13]
	assign port_o.tgt_wr_fifo_almost_empty_n =
		~(w_cnt == (WAW+1)'(ptf_pkg::AEMPTY_LEVEL)); // [RULE14]
	// single clock here, so the pci-side flag shares the fifo clock
	assign port_o.tgt_wr_fifo_full_n         = ~w_full; // [RULE15]
endmodule // ptf_core

// >>> design/ptf_app.sv
`timescale 1ns/1ns
module ptf_app #(
	parameter int DATA_W = ptf_pkg::DATA_W,
	parameter int ADDR_W = ptf_pkg::ADDR_W
) (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire logic                         clear_i,
	input  wire logic                         take_i,
	output      logic                         busy_o,
	output      logic                         cmd_valid_o,
	output      logic [ADDR_W-1:0]            addr_o,
	output      logic [ptf_pkg::CMD_W-1:0]    cmd_o,
	output      logic [ptf_pkg::REGION_W-1:0] region_o,
	output      logic                         data_valid_o,
	output      logic [DATA_W-1:0]            data_o,
	ptf_if.app                                port_i
);
	// ************************************************************
	// synchronise the pci-clock full flag
	// ************************************************************
	// the other core flags share this clock and are read directly
	logic fl1_q, fl2_q;
	always_ff @(posedge clk_i) begin
		fl1_q <= port_i.tgt_wr_fifo_full_n; // [RULE16]
		fl2_q <= fl1_q;
	end

	// ************************************************************
	// drive clear, enables
	// ************************************************************
	logic       clr_n_q, oe_n_q, en_n_q, en_prev_q;
	logic [2:0] oe_cnt_q, gap_q;
	// a word leaves the core exactly when the core sees this condition
	wire        popped   = ~en_n_q & port_i.tgt_wr_fifo_empty_n & clr_n_q;
	wire        may_take = oe_n_q && gap_q == 3'h0 && !port_i.tgt_req_n &&
		port_i.tgt_ready && take_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clr_n_q   <= 1'b1;
			oe_n_q    <= 1'b1;
			en_n_q    <= 1'b1;
			en_prev_q <= 1'b0;
			oe_cnt_q  <= '0;
			gap_q     <= '0;
			cmd_valid_o  <= 1'b0;
			data_valid_o <= 1'b0;
			addr_o    <= '0;
			cmd_o     <= '0;
			region_o  <= '0;
			data_o    <= '0;
		end else begin
			clr_n_q <= ~clear_i; // [RULE1]
			cmd_valid_o <= 1'b0;
			// hold enable until address and command have settled
			if (may_take) begin
				oe_n_q   <= 1'b0; // [RULE5] [RULE16]
				oe_cnt_q <= 3'(ptf_pkg::OE_HOLD);
			end else if (!oe_n_q) begin
				oe_cnt_q <= oe_cnt_q - 3'h1;
				if (oe_cnt_q == 3'h1) begin
					oe_n_q      <= 1'b1;
					// wait out the pop before judging the request again
					gap_q       <= 3'(ptf_pkg::OE_GAP);
					addr_o      <= port_i.tgt_addr;
					cmd_o       <= port_i.tgt_cmd; // [RULE8]
					region_o    <= port_i.tgt_region; // [RULE8]
					cmd_valid_o <= 1'b1;
				end
			end else if (gap_q != 3'h0) begin
				gap_q <= gap_q - 3'h1;
			end
			en_n_q    <= ~(take_i & port_i.tgt_ready); // [RULE11]
			en_prev_q <= popped;
			data_valid_o <= en_prev_q;
			if (en_prev_q)
				data_o <= port_i.data_to_fabric;
		end
	end
	assign busy_o = ~oe_n_q | ~fl2_q;
	assign port_i.tgt_fifo_clear_n = clr_n_q;
	assign port_i.tgt_addr_oe_n    = oe_n_q;
	assign port_i.tgt_wr_data_en_n = en_n_q;
endmodule // ptf_app

// >>> sim/ptf_sva.sv
`timescale 1ns/1ns
// ****************
// port checker
// ****************
module ptf_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        tgt_fifo_clear_n,
	input wire logic        tgt_req_n,
	input wire logic        tgt_ready,
	input wire logic        tgt_addr_oe_n,
	input wire logic [2:0]  tgt_region,
	input wire logic [2:0]  tgt_state_cnt,
	input wire logic        tgt_wr_data_en_n,
	input wire logic [63:0] data_to_fabric,
	input wire logic        tgt_wr_fifo_empty_n,
	input wire logic        tgt_wr_fifo_almost_empty_n,
	input wire logic        tgt_wr_fifo_full_n
);
	// cycles since the app last acted; saturates so it never wraps
	logic [3:0] quiet_q;
	logic [3:0] quiet_d;
	wire        act = !tgt_addr_oe_n || !tgt_wr_data_en_n || !tgt_fifo_clear_n;
	assign quiet_d = act ? 4'h0 : (quiet_q == 4'hF ? quiet_q : quiet_q + 4'h1);
	always_ff @(posedge clk_i) quiet_q <= rst_i ? 4'hF : quiet_d;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence clear_held; !tgt_fifo_clear_n [*4]; endsequence
	ready_clear_a: assert property (clear_held |-> !tgt_ready)
		else $error("ready high during clear");
	req_hold_a: assert property ($rose(tgt_req_n) |-> quiet_q <= 4'h8)
		else $error("request dropped without a pop");
	pop_only_a: assert property ($changed(data_to_fabric) |->
		$past(!tgt_wr_data_en_n) || $past(!tgt_fifo_clear_n))
		else $error("data moved without enable");
	region_ok_a: assert property (!tgt_req_n |-> tgt_region < 3'h6)
		else $error("region out of range");
	state_ok_a: assert property (tgt_state_cnt <= 3'h4)
		else $error("state code out of range");
	empty_excl_a: assert property (!tgt_wr_fifo_empty_n |->
		tgt_wr_fifo_full_n && tgt_wr_fifo_almost_empty_n)
		else $error("empty with other flag");
	full_excl_a: assert property (!tgt_wr_fifo_full_n |->
		tgt_wr_fifo_empty_n && tgt_wr_fifo_almost_empty_n)
		else $error("full with other flag");
	aempty_ok_a: assert property ($fell(tgt_wr_fifo_almost_empty_n) |-> tgt_wr_fifo_empty_n)
		else $error("almost empty while empty");
endmodule // ptf_checker

// >>> sim/pci_target_fifo_user_port_bench.sv
`timescale 1ns/1ns
// ****************
// bench
// ****************
module pci_target_fifo_user_port_bench;
	logic clk_i = 0, rst_i = 1, pci_rst_i = 0, clear_i = 0, take_i = 0;
	logic req_valid_i = 0, req_write_i = 0, wdata_valid_i = 0;
	logic [31:0] req_addr_i = 0;
	logic [3:0]  req_cmd_i = 0;
	logic [2:0]  req_region_i = 0;
	logic [63:0] wdata_i = 0, data_o;
	logic req_ready_o, wdata_ready_o, busy_o, cmd_valid_o, data_valid_o;
	logic [31:0] addr_o;
	logic [3:0]  cmd_o;
	logic [2:0]  region_o;
	logic [38:0] rq[$];
	logic [63:0] dq[$];
	int miscompares = 0, checks = 0, cyc = 0, n;
	ptf_if ptf_if_i ();
	ptf_core ptf_core_i (.clk_i(clk_i), .rst_i(rst_i), .pci_rst_i(pci_rst_i),
		.req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_addr_i(req_addr_i),
		.req_cmd_i(req_cmd_i), .req_region_i(req_region_i), .req_write_i(req_write_i),
		.wdata_valid_i(wdata_valid_i), .wdata_ready_o(wdata_ready_o), .wdata_i(wdata_i),
		.port_o(ptf_if_i));
	ptf_app ptf_app_i (.clk_i(clk_i), .rst_i(rst_i), .clear_i(clear_i), .take_i(take_i),
		.busy_o(busy_o), .cmd_valid_o(cmd_valid_o), .addr_o(addr_o), .cmd_o(cmd_o),
		.region_o(region_o), .data_valid_o(data_valid_o), .data_o(data_o), .port_i(ptf_if_i));
	ptf_checker ptf_checker_i (.clk_i(clk_i), .rst_i(rst_i),
		.tgt_fifo_clear_n(ptf_if_i.tgt_fifo_clear_n), .tgt_req_n(ptf_if_i.tgt_req_n),
		.tgt_ready(ptf_if_i.tgt_ready), .tgt_addr_oe_n(ptf_if_i.tgt_addr_oe_n),
		.tgt_region(ptf_if_i.tgt_region), .tgt_state_cnt(ptf_if_i.tgt_state_cnt),
		.tgt_wr_data_en_n(ptf_if_i.tgt_wr_data_en_n),
		.data_to_fabric(ptf_if_i.data_to_fabric),
		.tgt_wr_fifo_empty_n(ptf_if_i.tgt_wr_fifo_empty_n),
		.tgt_wr_fifo_almost_empty_n(ptf_if_i.tgt_wr_fifo_almost_empty_n),
		.tgt_wr_fifo_full_n(ptf_if_i.tgt_wr_fifo_full_n));
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("miscompares=%0d checks=%0d", miscompares, checks);
		if (miscompares == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ready is combinational: judged at negedge, held until the taking edge
	task automatic push_wd(input logic [63:0] d);
		@(posedge clk_i) #1 wdata_valid_i = 1;
		wdata_i = d;
		do @(negedge clk_i); while (wdata_ready_o !== 1'b1);
		@(posedge clk_i) #1 wdata_valid_i = 0;
	endtask
	// model: outputs must follow the pushed order
	always @(negedge clk_i) begin
		if (cmd_valid_o === 1'b1)
			check({addr_o, cmd_o, region_o}, rq.size() ? rq.pop_front() : 39'h0);
		if (data_valid_o === 1'b1)
			check(data_o, dq.size() ? dq.pop_front() : ~data_o);
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up();
		end
	end
	initial begin
		n = $urandom(49309);
		repeat (10) @(posedge clk_i);
		#1 rst_i = 0;
		repeat (4) @(negedge clk_i);
		check(ptf_if_i.tgt_wr_fifo_empty_n, 0);
		check(ptf_if_i.tgt_ready, 1);
		for (int k = 1; k <= 16; k++) begin
			dq.push_back({$urandom, $urandom});
			push_wd(dq[k-1]);
			@(negedge clk_i);
			check(ptf_if_i.tgt_wr_fifo_empty_n, 1);
			check(ptf_if_i.tgt_wr_fifo_almost_empty_n, k != 4);
			check(ptf_if_i.tgt_wr_fifo_full_n, k != 16);
		end
		check(wdata_ready_o, 0);
		repeat (2) @(negedge clk_i);
		check(busy_o, 1);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_i) #1 req_valid_i = 1;
			{req_addr_i, req_cmd_i, req_region_i} = {$urandom, 4'($urandom), 3'($urandom)};
			// the first names a region that does not exist and must be dropped
			if (i == 0) req_region_i = 3'h7;
			req_write_i = 1'($urandom);
			if (req_region_i < 3'h6) rq.push_back({req_addr_i, req_cmd_i, req_region_i});
			do @(negedge clk_i); while (req_ready_o !== 1'b1);
			@(posedge clk_i) #1 req_valid_i = 0;
		end
		repeat (3) @(negedge clk_i);
		check(ptf_if_i.tgt_req_n, rq.size() == 0);
		if (rq.size()) check({ptf_if_i.tgt_cmd, ptf_if_i.tgt_region}, rq[0][6:0]);
		check(ptf_if_i.tgt_state_cnt,
			rq.size() ? ptf_pkg::PTF_ST_ADDR : ptf_pkg::PTF_ST_IDLE);
		@(posedge clk_i) #1 take_i = 1;
		for (n = 0; n < 3000 && (rq.size() || dq.size()); n++) @(negedge clk_i);
		repeat (10) @(negedge clk_i);
		check(rq.size() + dq.size(), 0);
		check(ptf_if_i.tgt_req_n, 1);
		check(ptf_if_i.tgt_wr_fifo_empty_n, 0);
		check(ptf_if_i.tgt_state_cnt, ptf_pkg::PTF_ST_IDLE);
		check(busy_o, 0);
		@(posedge clk_i) #1 take_i = 0;
		push_wd(64'h0123456789ABCDEF);
		clear_i = 1;
		repeat (6) @(negedge clk_i);
		check(ptf_if_i.tgt_ready, 0);
		@(posedge clk_i) #1 clear_i = 0;
		repeat (8) @(negedge clk_i);
		check(ptf_if_i.tgt_ready, 1);
		check(ptf_if_i.tgt_wr_fifo_empty_n, 0);
		@(posedge clk_i) #1 pci_rst_i = 1;
		repeat (3) @(negedge clk_i);
		check(ptf_if_i.tgt_ready, 0);
		@(posedge clk_i) #1 pci_rst_i = 0;
		repeat (4) @(negedge clk_i);
		check(ptf_if_i.tgt_ready, 1);
		wrap_up();
	end
endmodule // pci_target_fifo_user_port_bench
